// File: shared/cor_defs.vh
// Purpose: constants for the coast and output control register bank
// Assumes: 8-bit register port, 40 MHz clock
// Notes:   offsets are the printed register indexes
`ifndef COR_DEFS_VH
`define COR_DEFS_VH
`define COR_ADDR_W        8
`define COR_OFS_VSYNC     8'h10
`define COR_OFS_CLAMP     8'h11
`define COR_OFS_PRECOAST  8'h12
`define COR_OFS_POSTCOAST 8'h13
`define COR_OFS_OUTCTL    8'h14
`define COR_OFS_STATUS    8'h15
`define COR_RST_VSYNC     8'h00
`define COR_RST_CLAMP     8'h0a
`define COR_RST_PRECOAST  8'h00
`define COR_RST_POSTCOAST 8'h00
`define COR_RST_OUTCTL    8'he2
`define COR_BIT_VS_SEL    0
`define COR_BIT_VS_OVR    1
`define COR_BIT_CST_POL   1
`define COR_BIT_CST_OVR   2
`define COR_BIT_CST_EN    3
`define COR_BIT_BLU_CLAMP 4
`define COR_BIT_FMT422    0
`define COR_BIT_SLEEP_N   1
`define COR_BIT_HDCP_ADR  2
`define COR_BIT_FLOAT     3
`define COR_BIT_CLK_INV   4
`define COR_BIT_BW        5
`define COR_BIT_DRV_HI    7
`define COR_BIT_DRV_LO    6
`define COR_BIT_HS_ACT    7
`define COR_DRV_LOW       2'b00
`define COR_DRV_MED       2'b01
`define COR_DRV_HIGH      2'b11
`define COR_RDATA_IDLE    8'h00
`define COR_TIMEOUT_NS    200000
`define COR_CLK_NS        25
`endif

// File: verilog/cor_regs.v
// Purpose: coast, clamp, output and power control registers with line sync activity detect
// Assumes: single 40 MHz clock, registers on a plain strobe port
// Notes:   drives static controls toward the converter datapath
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "cor_defs.vh"

// Notes on behaviour
// - blue clamp bit 4: 0 ground, 1 midscale; resets 0
// - coast enable bit 3: 0 off, 1 internal coast; resets 1
// - enabled coast source follows vertical sync override/select choice
// - polarity override bit 2: 0 automatic, 1 from user bit; resets 0
// - override acts only with coast disabled, never on internal coast
// - polarity bit 1: 0 active low, 1 active high; resets 1
// - precoast byte: sync edges filtered before vertical sync; resets 0
// - postcoast byte: edges filtered after vertical sync, line steps; resets 0
// - drive field 7-6: 1x high, 01 medium, 00 low; resets 11
// - bandwidth bit 5: 0 selects 10 MHz, 1 selects 300 MHz
// - clock invert bit 4 digital mode only; resets 0
// - float bit 3 tri-states data and sync/enable outputs; resets 0
// - bit 2 drives content-protection slave address bit; resets 0
// - sleep bit 1 active low: 0 power-down, 1 normal; resets 1
// - format bit 0: 0 4:4:4, 1 4:2:2 with 16 lines
// - 4:2:2: green luma, red alternating chroma, blue floated
// - status bit 7 reads 1 while line sync pin toggles
// - vertical override set: select 0 pin, 1 sync separator
module cor_regs #(
  parameter TIMEOUT_CYC = (`COR_TIMEOUT_NS + `COR_CLK_NS - 1) / `COR_CLK_NS,
  parameter CNT_W       = 16
) (
  // clock and reset
  input  wire                   i_clock,
  input  wire                   i_rst,
  // register port
  input  wire [`COR_ADDR_W-1:0] i_addr,
  input  wire [7:0]             i_wdata,
  input  wire                   i_wr,
  input  wire                   i_rd,
  output reg  [7:0]             o_rdata,
  // pins and datapath status
  input  wire                   i_line_sync_pin,
  input  wire                   i_digital_mode,
  input  wire                   i_auto_vsync_sep,
  input  wire                   i_auto_coast_pol,
  // controls toward datapath
  output wire                   o_blue_clamp_mid,
  output wire                   o_coast_en,
  output wire                   o_coast_from_sep,
  output wire                   o_coast_active_high,
  output wire [7:0]             o_precoast,
  output wire [7:0]             o_postcoast,
  output wire [1:0]             o_drive,
  output wire                   o_bw_wide,
  output wire                   o_clk_invert,
  output wire                   o_output_float_ctl,
  output wire                   o_hdcp_addr_bit,
  output wire                   o_chip_sleep_n,
  output wire                   o_fmt_422,
  output wire                   o_red_oe,
  output wire                   o_green_oe,
  output wire                   o_blue_oe,
  output wire                   o_sync_de_oe
);

  // register state and next values
  reg  [7:0]       vsync_r;
  reg  [7:0]       vsync_nxt;
  reg  [7:0]       clamp_r;
  reg  [7:0]       clamp_nxt;
  reg  [7:0]       pre_r;
  reg  [7:0]       pre_nxt;
  reg  [7:0]       post_r;
  reg  [7:0]       post_nxt;
  reg  [7:0]       outctl_r;
  reg  [7:0]       outctl_nxt;
  reg  [7:0]       rdata_nxt;
  // line sync detector state
  reg  [2:0]       hs_sync_r;
  reg  [2:0]       hs_vld_r;
  reg              hs_lvl_r;
  reg              hs_lvl_nxt;
  reg              hs_primed_r;
  reg              hs_primed_nxt;
  reg              hs_act_r;
  reg              hs_act_nxt;
  reg  [CNT_W-1:0] idle_r;
  reg  [CNT_W-1:0] idle_nxt;
  // decodes
  wire             wr_vsync;
  wire             wr_clamp;
  wire             wr_pre;
  wire             wr_post;
  wire             wr_outctl;
  wire             hs_agree;
  wire             hs_edge;
  wire             hs_stable;
  wire             cst_dis;

  // address match on the register port
  function sel_hit;
    input [`COR_ADDR_W-1:0] a;
    input [`COR_ADDR_W-1:0] ofs;
    begin
      sel_hit = (a == ofs);
    end
  endfunction

  // write strobe qualified by address
  function wr_hit;
    input                   wr;
    input [`COR_ADDR_W-1:0] a;
    input [`COR_ADDR_W-1:0] ofs;
    begin
      wr_hit = wr & sel_hit(a, ofs);
    end
  endfunction

  // drive field to strength code, upper bit dominates
  function [1:0] drive_code;
    input [1:0] field;
    begin
      if (field[1])
        drive_code = `COR_DRV_HIGH;
      else if (field[0])
        drive_code = `COR_DRV_MED;
      else
        drive_code = `COR_DRV_LOW;
    end
  endfunction

  // status byte, only the activity flag is implemented
  function [7:0] status_byte;
    input flag;
    begin
      status_byte                  = `COR_RDATA_IDLE;
      status_byte[`COR_BIT_HS_ACT] = flag;
    end
  endfunction

  // write decodes
  assign wr_vsync  = wr_hit(i_wr, i_addr, `COR_OFS_VSYNC);
  assign wr_clamp  = wr_hit(i_wr, i_addr, `COR_OFS_CLAMP);
  assign wr_pre    = wr_hit(i_wr, i_addr, `COR_OFS_PRECOAST);
  assign wr_post   = wr_hit(i_wr, i_addr, `COR_OFS_POSTCOAST);
  assign wr_outctl = wr_hit(i_wr, i_addr, `COR_OFS_OUTCTL);

  // vertical sync source choice, bits 1 and 0 used
  always @* begin
    vsync_nxt = vsync_r;
    if (wr_vsync)
      vsync_nxt = i_wdata;
  end

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst)
      vsync_r <= `COR_RST_VSYNC;
    else
      vsync_r <= vsync_nxt;
  end

  // clamp and coast control
  always @* begin
    clamp_nxt = clamp_r;
    if (wr_clamp)
      clamp_nxt = i_wdata;
  end

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst)
      clamp_r <= `COR_RST_CLAMP;
    else
      clamp_r <= clamp_nxt;
  end

  // edges filtered ahead of vertical sync
  always @* begin
    pre_nxt = pre_r;
    if (wr_pre)
      pre_nxt = i_wdata;
  end

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst)
      pre_r <= `COR_RST_PRECOAST;
    else
      pre_r <= pre_nxt;
  end

  // edges filtered after vertical sync
  always @* begin
    post_nxt = post_r;
    if (wr_post)
      post_nxt = i_wdata;
  end

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst)
      post_r <= `COR_RST_POSTCOAST;
    else
      post_r <= post_nxt;
  end

  // output and power control
  always @* begin
    outctl_nxt = outctl_r;
    if (wr_outctl)
      outctl_nxt = i_wdata;
  end

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst)
      outctl_r <= `COR_RST_OUTCTL;
    else
      outctl_r <= outctl_nxt;
  end

  // read mux, status register is read only
  always @* begin
    rdata_nxt = `COR_RDATA_IDLE;
    if (i_rd) begin
      case (i_addr)
        `COR_OFS_VSYNC:     rdata_nxt = vsync_r;
        `COR_OFS_CLAMP:     rdata_nxt = clamp_r;
        `COR_OFS_PRECOAST:  rdata_nxt = pre_r;
        `COR_OFS_POSTCOAST: rdata_nxt = post_r;
        `COR_OFS_OUTCTL:    rdata_nxt = outctl_r;
        `COR_OFS_STATUS:    rdata_nxt = status_byte(hs_act_r);
        default:            rdata_nxt = `COR_RDATA_IDLE;
      endcase
    end
  end

  // data stands one cycle after the strobe, zero otherwise
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst)
      o_rdata <= `COR_RDATA_IDLE;
    else
      o_rdata <= rdata_nxt;
  end

  // line sync pin: three stages, a level counts once stages two and three agree
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      hs_sync_r <= 3'b000;
      hs_vld_r  <= 3'b000;
    end else begin
      hs_sync_r <= {hs_sync_r[1:0], i_line_sync_pin};
      hs_vld_r  <= {hs_vld_r[1:0], 1'b1};
    end
  end

  assign hs_agree = (hs_sync_r[1] == hs_sync_r[2]);
  // first settled level after reset only primes, so an idle-high pin gives no false edge
  assign hs_edge  = hs_agree & hs_primed_r & (hs_sync_r[2] != hs_lvl_r);

  always @* begin
    hs_lvl_nxt    = hs_lvl_r;
    hs_primed_nxt = hs_primed_r;
    if (hs_agree && (hs_primed_r || hs_vld_r[2])) begin
      hs_lvl_nxt    = hs_sync_r[2];
      hs_primed_nxt = 1'b1;
    end
  end

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      hs_lvl_r    <= 1'b0;
      hs_primed_r <= 1'b0;
    end else begin
      hs_lvl_r    <= hs_lvl_nxt;
      hs_primed_r <= hs_primed_nxt;
    end
  end

  // activity flag with idle timeout
  assign hs_stable = (idle_r == TIMEOUT_CYC[CNT_W-1:0]);

  always @* begin
    idle_nxt   = idle_r;
    hs_act_nxt = hs_act_r;
    if (hs_edge) begin
      idle_nxt   = {CNT_W{1'b0}};
      hs_act_nxt = 1'b1;
    end else if (hs_stable) begin
      hs_act_nxt = 1'b0;
    end else begin
      idle_nxt   = idle_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      idle_r   <= {CNT_W{1'b0}};
      hs_act_r <= 1'b0;
    end else begin
      idle_r   <= idle_nxt;
      hs_act_r <= hs_act_nxt;
    end
  end

  // coast control
  assign cst_dis          = ~clamp_r[`COR_BIT_CST_EN];
  assign o_blue_clamp_mid = clamp_r[`COR_BIT_BLU_CLAMP];
  assign o_coast_en       = clamp_r[`COR_BIT_CST_EN];
  // source follows vertical sync choice
  assign o_coast_from_sep = vsync_r[`COR_BIT_VS_OVR] ?
                            vsync_r[`COR_BIT_VS_SEL] :
                            i_auto_vsync_sep;
  // user polarity only with coast off and override set
  assign o_coast_active_high = (cst_dis && clamp_r[`COR_BIT_CST_OVR]) ?
                               clamp_r[`COR_BIT_CST_POL] :
                               i_auto_coast_pol;
  assign o_precoast       = pre_r;
  assign o_postcoast      = post_r;

  // output control
  assign o_drive = drive_code(outctl_r[`COR_BIT_DRV_HI:`COR_BIT_DRV_LO]);
  assign o_bw_wide          = outctl_r[`COR_BIT_BW];
  assign o_clk_invert       = outctl_r[`COR_BIT_CLK_INV] & i_digital_mode;
  assign o_output_float_ctl = outctl_r[`COR_BIT_FLOAT];
  assign o_hdcp_addr_bit    = outctl_r[`COR_BIT_HDCP_ADR];
  assign o_chip_sleep_n     = outctl_r[`COR_BIT_SLEEP_N];
  assign o_fmt_422          = outctl_r[`COR_BIT_FMT422];
  assign o_red_oe           = ~o_output_float_ctl;
  assign o_green_oe         = ~o_output_float_ctl;
  assign o_blue_oe          = ~o_output_float_ctl & ~o_fmt_422;
  assign o_sync_de_oe       = ~o_output_float_ctl;

endmodule // cor_regs
`default_nettype wire

// File: verification/cor_regs_assertions.sv
// Purpose: port checks for cor_regs
// Assumes: one clock, async reset active high
// Notes:   bound to every cor_regs instance
`timescale 1ns/1ps
`default_nettype none
module cor_regs_chk (
  input wire       i_clock,
  input wire       i_rst,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire       i_wr,
  input wire       i_rd,
  input wire [7:0] o_rdata,
  input wire [1:0] o_drive,
  input wire       o_fmt_422,
  input wire       o_output_float_ctl,
  input wire       o_blue_oe,
  input wire       o_sync_de_oe
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire w14 = i_wr && (i_addr == 8'h14);
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata not idle");
  a_unmapped_read: assert property (i_rd && i_addr > 8'h15 |=> o_rdata == 8'h00) else $error("bad");
  a_status_low_bits: assert property (i_rd && i_addr == 8'h15 |=> o_rdata[6:0] == 7'h00)
    else $error("status low bits set");
  a_drive_map: assert property (w14 |=> o_drive == ($past(i_wdata[7]) ? 2'b11 : 2'b00 |
    $past(i_wdata[7:6]))) else $error("drive mapping wrong");
  a_fmt_write: assert property (w14 |=> o_fmt_422 == $past(i_wdata[0])) else $error("fmt");
  a_fmt_hold: assert property (!w14 |=> $stable(o_fmt_422)) else $error("fmt changed");
  a_float_outputs: assert property (o_output_float_ctl |-> !o_sync_de_oe && !o_blue_oe)
    else $error("outputs driven while floated");
  a_blue_oe_map: assert property (o_blue_oe == (!o_output_float_ctl && !o_fmt_422))
    else $error("blue enable wrong");
  c_outctl_write: cover property (w14);
  c_status_read: cover property (i_rd && i_addr == 8'h15);
  c_packed_mode: cover property (o_fmt_422 && !o_blue_oe);
endmodule // cor_regs_chk
bind cor_regs cor_regs_chk cor_regs_chk_i (.*);
`default_nettype wire

// File: verification/tb.sv
// Purpose: register and control checks for cor_regs
// Assumes: 40 MHz clock, short activity timeout
// Notes:   bench drives all ports directly
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       i_clock = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_line_sync_pin = 1'b0;
  logic       i_digital_mode = 1'b0, i_auto_vsync_sep = 1'b0, i_auto_coast_pol = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
  wire  [7:0] o_rdata, o_precoast, o_postcoast;
  wire  [1:0] o_drive;
  wire        o_blue_clamp_mid, o_coast_en, o_coast_from_sep, o_coast_active_high, o_bw_wide;
  wire        o_clk_invert, o_output_float_ctl, o_hdcp_addr_bit, o_chip_sleep_n, o_fmt_422;
  wire        o_red_oe, o_green_oe, o_blue_oe, o_sync_de_oe;
  int         fail_count = 0, cmp_count = 0;
  cor_regs #(.TIMEOUT_CYC(20)) cor_regs_i (.*);
  always #12.5 i_clock = ~i_clock;
  task chk(input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge i_clock);
    {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
    @(posedge i_clock);
    i_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge i_clock);
    {i_addr, i_rd} <= {a, 1'b1};
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  task complete_run;
    if (fail_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(8'h11, 8'h0a);
    rd(8'h14, 8'he2);
    rd(8'h13, 8'h00);
    rd(8'h12, 8'h00);
    wr(8'h12, 8'ha5);
    chk(o_precoast, 8'ha5);
    rd(8'h12, 8'ha5);
    wr(8'h13, 8'h5a);
    chk(o_postcoast, 8'h5a);
    rd(8'h13, 8'h5a);
    wr(8'h15, 8'hff);
    rd(8'h15, 8'h00);
    rd(8'h20, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'h14, {i[1:0], 6'h3d});
      chk({o_drive, o_bw_wide, o_clk_invert, o_blue_oe}, {i[1] ? 2'b11 : i[1:0], 3'b100});
    end
    chk({o_output_float_ctl, o_hdcp_addr_bit, o_chip_sleep_n, o_sync_de_oe}, 8'h0c);
    @(posedge i_clock) i_digital_mode <= 1'b1;
    #1 chk(o_clk_invert, 8'h01);
    wr(8'h14, 8'h01);
    chk({o_red_oe, o_green_oe, o_blue_oe, o_sync_de_oe, o_chip_sleep_n}, 8'h1a);
    wr(8'h10, 8'h03);
    chk(o_coast_from_sep, 8'h01);
    wr(8'h10, 8'h02);
    chk(o_coast_from_sep, 8'h00);
    wr(8'h10, 8'h00);
    @(posedge i_clock) i_auto_vsync_sep <= 1'b1;
    #1 chk(o_coast_from_sep, 8'h01);
    wr(8'h11, 8'h16);
    chk({o_blue_clamp_mid, o_coast_en, o_coast_active_high}, 8'h05);
    wr(8'h11, 8'h0e);
    chk({o_blue_clamp_mid, o_coast_en, o_coast_active_high}, 8'h02);
    @(posedge i_clock) i_auto_coast_pol <= 1'b1;
    #1 chk(o_coast_active_high, 8'h01);
    wr(8'h11, 8'h04);
    chk({o_blue_clamp_mid, o_coast_en, o_coast_active_high}, 8'h00);
    repeat (6) begin
      repeat (4) @(posedge i_clock);
      i_line_sync_pin <= ~i_line_sync_pin;
    end
    rd(8'h15, 8'h80);
    repeat (30) @(posedge i_clock);
    rd(8'h15, 8'h00);
    complete_run;
  end
endmodule // tb
`default_nettype wire
